// file: rtl/seg_pkg.sv
// constants of the segment display global control block
// assumes one 20 MHz bus clock and an AHB-Lite master
package seg_pkg;

  // register byte addresses
  localparam logic [11:0] OFS_GLOBAL_CONTROL = 12'h000;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h004;
  localparam logic [11:0] OFS_IRQ_CLEAR = 12'h008;
  localparam logic [11:0] OFS_IRQ_ENABLE = 12'h00C;

  // global control field positions
  localparam int BIT_SUPPLY = 17;
  localparam int BIT_PAD_SAFE = 15;
  localparam int BIT_FAULT_IRQ_EN = 14;
  localparam int BIT_DIV_HI = 13;
  localparam int BIT_DIV_LO = 12;
  localparam int BIT_ALT_SEL = 11;
  localparam int BIT_FAST = 10;
  localparam int BIT_DOZE_STOP = 9;
  localparam int BIT_DRIVER_EN = 7;

  // writable bits of the global control word
  localparam logic [31:0] GCR_WMASK = 32'h0002_FE80;
  localparam logic [31:0] GCR_RESET = 32'h0000_0000;

  // interrupt status layout
  localparam int IRQ_BITS = 2;
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_FRAME = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  // alternate clock divider codes
  localparam logic [1:0] DIV_1 = 2'h0;
  localparam logic [1:0] DIV_8 = 2'h1;
  localparam logic [1:0] DIV_64 = 2'h2;
  localparam logic [1:0] DIV_512 = 2'h3;
  localparam logic [8:0] LIM_1 = 9'h000;
  localparam logic [8:0] LIM_8 = 9'h007;
  localparam logic [8:0] LIM_64 = 9'h03F;
  localparam logic [8:0] LIM_512 = 9'h1FF;

  // display clock ticks per standard frame
  localparam logic [7:0] FRAME_TICKS = 8'h40;

  // bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

endpackage : seg_pkg

// file: rtl/seg_alt_div.sv
// alternate clock power-of-eight divider
// assumes tick_in is a one-cycle enable on hclk
`timescale 1ns/1ps
module seg_alt_div (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic [1:0] code,
  input wire logic tick_in,
  // divided enable
  output logic tick_out
);

  typedef struct packed {
    logic [8:0] cnt;
    logic tick;
  } seg_div_s;

  seg_div_s st_ff;
  seg_div_s nxt_st;
  logic [8:0] lim;

  always_comb begin
    case (code)
      seg_pkg::DIV_1: lim = seg_pkg::LIM_1;
      seg_pkg::DIV_8: lim = seg_pkg::LIM_8;
      seg_pkg::DIV_64: lim = seg_pkg::LIM_64;
      default: lim = seg_pkg::LIM_512;
    endcase
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (tick_in) begin
      if (st_ff.cnt >= lim) begin
        nxt_st.cnt = 9'h000;
        nxt_st.tick = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt + 9'h001;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick_out = st_ff.tick;

endmodule : seg_alt_div

// file: rtl/seg_frame_gen.sv
// frame tick generator from the display clock enable
// assumes lcd_tick is a one-cycle enable on hclk
`timescale 1ns/1ps
module seg_frame_gen (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic run,
  input wire logic fast,
  input wire logic lcd_tick,
  // frame enable
  output logic frame_tick
);

  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } seg_frm_s;

  seg_frm_s st_ff;
  seg_frm_s nxt_st;
  logic [7:0] lim;

  always_comb begin
    // half the count gives twice the rate
    lim = fast ? (seg_pkg::FRAME_TICKS >> 1) - 8'h01
               : seg_pkg::FRAME_TICKS - 8'h01;
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (!run) begin
      nxt_st.cnt = 8'h00;
    end else if (lcd_tick) begin
      if (st_ff.cnt >= lim) begin
        nxt_st.cnt = 8'h00;
        nxt_st.tick = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign frame_tick = st_ff.tick;

endmodule : seg_frame_gen

// file: rtl/seg_global_ctrl.sv
// segment display global control: AHB-Lite slave, clock path, pad control
// assumes alternate clock ticks on hclk and an asynchronous doze pin
`timescale 1ns/1ps
module seg_global_ctrl (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // alternate clock sources, enables on hclk
  input wire logic alt_src1_tick,
  input wire logic alt_src2_tick,
  // system and fault events
  input wire logic doze_mode,
  input wire logic fault_done_pulse,
  // display clock and frame
  output logic lcd_clk_tick,
  output logic frame_tick,
  // pad and analog control
  output logic pads_enable,
  output logic waveform_run,
  output logic charge_pump_run,
  output logic bias_network_run,
  output logic regulator_run,
  output logic top_bias_rail_internal,
  output logic top_bias_rail_external,
  // interrupt
  output logic irq
);

  typedef struct packed {
    logic ph_valid;
    logic ph_write;
    logic [11:0] ph_addr;
    logic supply_source_select;
    logic pad_safe_override;
    logic fault_done_irq_enable;
    logic [1:0] alt_clock_divider;
    logic alt_clock_select;
    logic fast_frame_rate;
    logic doze_stop;
    logic driver_enable;
    logic [1:0] irq_status;
    logic frame_irq_enable;
    logic [31:0] rdata;
    logic doze_s1;
    logic doze_s2;
    logic doze_s3;
    logic doze_level;
    logic run;
    logic pads;
    logic rail_int;
    logic rail_ext;
    logic irq;
  } seg_top_s;

  seg_top_s st_ff;
  seg_top_s nxt_st;

  logic alt_raw_tick;
  logic alt_div_tick;
  logic frame_raw_tick;
  logic addr_take;
  logic [31:0] gcr_word;
  logic [1:0] irq_en_word;
  logic [1:0] clr_bits;
  logic [1:0] set_bits;

  // alternate source choice
  assign alt_raw_tick = st_ff.alt_clock_select ? alt_src2_tick
                                               : alt_src1_tick;

  seg_alt_div u_alt_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .code(st_ff.alt_clock_divider),
    .tick_in(alt_raw_tick),
    .tick_out(alt_div_tick)
  );

  seg_frame_gen u_frame (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(st_ff.run),
    .fast(st_ff.fast_frame_rate),
    .lcd_tick(alt_div_tick),
    .frame_tick(frame_raw_tick)
  );

  // address phase acceptance
  assign addr_take = hsel && hready && (htrans == seg_pkg::HTRANS_NONSEQ ||
                     htrans == 2'h3);

  always_comb begin
    nxt_st = st_ff;
    gcr_word = 32'h0000_0000;
    irq_en_word = 2'h0;
    clr_bits = 2'h0;
    set_bits = 2'h0;

    // data phase write
    if (st_ff.ph_valid && st_ff.ph_write) begin
      if (st_ff.ph_addr == seg_pkg::OFS_GLOBAL_CONTROL) begin
        // reserved positions are never stored
        nxt_st.supply_source_select =
          hwdata[seg_pkg::BIT_SUPPLY];
        nxt_st.pad_safe_override = hwdata[seg_pkg::BIT_PAD_SAFE];
        nxt_st.fault_done_irq_enable = hwdata[seg_pkg::BIT_FAULT_IRQ_EN];
        nxt_st.alt_clock_divider =
          hwdata[seg_pkg::BIT_DIV_HI:seg_pkg::BIT_DIV_LO];
        nxt_st.alt_clock_select = hwdata[seg_pkg::BIT_ALT_SEL];
        nxt_st.fast_frame_rate = hwdata[seg_pkg::BIT_FAST];
        nxt_st.doze_stop = hwdata[seg_pkg::BIT_DOZE_STOP];
        nxt_st.driver_enable = hwdata[seg_pkg::BIT_DRIVER_EN];
      end else if (st_ff.ph_addr == seg_pkg::OFS_IRQ_CLEAR) begin
        clr_bits = hwdata[seg_pkg::IRQ_BITS-1:0];
      end else if (st_ff.ph_addr == seg_pkg::OFS_IRQ_ENABLE) begin
        // fault enable shares storage with the control word
        nxt_st.fault_done_irq_enable = hwdata[seg_pkg::IRQ_FAULT];
        nxt_st.frame_irq_enable = hwdata[seg_pkg::IRQ_FRAME];
      end
    end

    // sticky status, set wins over clear
    set_bits[seg_pkg::IRQ_FAULT] = fault_done_pulse;
    set_bits[seg_pkg::IRQ_FRAME] = frame_raw_tick;
    nxt_st.irq_status = (st_ff.irq_status & ~clr_bits) | set_bits;

    // doze pin synchroniser, change taken when stages two and three agree
    nxt_st.doze_s1 = doze_mode;
    nxt_st.doze_s2 = st_ff.doze_s1;
    nxt_st.doze_s3 = st_ff.doze_s2;
    if (st_ff.doze_s2 == st_ff.doze_s3) begin
      nxt_st.doze_level = st_ff.doze_s3;
    end

    // analog and waveform run control
    nxt_st.run = nxt_st.driver_enable &&
                 !(nxt_st.doze_stop && nxt_st.doze_level);
    nxt_st.pads = nxt_st.run && !nxt_st.pad_safe_override;
    // top rail fed from main supply unless taken externally
    nxt_st.rail_int = !nxt_st.supply_source_select ||
                      !nxt_st.driver_enable;
    nxt_st.rail_ext = nxt_st.supply_source_select &&
                      nxt_st.driver_enable;

    // interrupt level
    irq_en_word[seg_pkg::IRQ_FAULT] = nxt_st.fault_done_irq_enable;
    irq_en_word[seg_pkg::IRQ_FRAME] = nxt_st.frame_irq_enable;
    nxt_st.irq = |(nxt_st.irq_status & irq_en_word);

    // read data from the values as they stand after this edge
    gcr_word[seg_pkg::BIT_SUPPLY] = nxt_st.supply_source_select;
    gcr_word[seg_pkg::BIT_PAD_SAFE] = nxt_st.pad_safe_override;
    gcr_word[seg_pkg::BIT_FAULT_IRQ_EN] = nxt_st.fault_done_irq_enable;
    gcr_word[seg_pkg::BIT_DIV_HI:seg_pkg::BIT_DIV_LO] =
      nxt_st.alt_clock_divider;
    gcr_word[seg_pkg::BIT_ALT_SEL] = nxt_st.alt_clock_select;
    gcr_word[seg_pkg::BIT_FAST] = nxt_st.fast_frame_rate;
    gcr_word[seg_pkg::BIT_DOZE_STOP] = nxt_st.doze_stop;
    gcr_word[seg_pkg::BIT_DRIVER_EN] = nxt_st.driver_enable;
    gcr_word = gcr_word & seg_pkg::GCR_WMASK;

    // address phase capture
    nxt_st.ph_valid = addr_take;
    if (addr_take) begin
      nxt_st.ph_write = hwrite;
      nxt_st.ph_addr = haddr[11:0];
      nxt_st.rdata = 32'h0000_0000;
      if (!hwrite) begin
        if (haddr[31:12] != 20'h00000) begin
          nxt_st.rdata = 32'h0000_0000;
        end else if (haddr[11:0] == seg_pkg::OFS_GLOBAL_CONTROL) begin
          nxt_st.rdata = gcr_word;
        end else if (haddr[11:0] == seg_pkg::OFS_IRQ_STATUS) begin
          nxt_st.rdata = {30'h0000_0000, nxt_st.irq_status};
        end else if (haddr[11:0] == seg_pkg::OFS_IRQ_ENABLE) begin
          nxt_st.rdata = {30'h0000_0000, irq_en_word};
        end else begin
          nxt_st.rdata = 32'h0000_0000;
        end
      end
      if (haddr[31:12] != 20'h00000) begin
        // out of window: nothing decodes
        nxt_st.ph_addr = 12'hFFF;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
      st_ff.rail_int <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // zero wait state, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_ff.rdata;

  assign lcd_clk_tick = alt_div_tick;
  assign frame_tick = frame_raw_tick;
  assign pads_enable = st_ff.pads;
  assign waveform_run = st_ff.run;
  assign charge_pump_run = st_ff.run;
  assign bias_network_run = st_ff.run;
  assign regulator_run = st_ff.run;
  assign top_bias_rail_internal = st_ff.rail_int;
  assign top_bias_rail_external = st_ff.rail_ext;
  assign irq = st_ff.irq;

endmodule : seg_global_ctrl

// file: bench/seg_ctrl_sva.sv
// port checker for the global control block
// bound to seg_global_ctrl, watches its ports only
`timescale 1ns/1ps
module seg_ctrl_sva (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  // events
  input wire logic alt_src1_tick,
  input wire logic alt_src2_tick,
  input wire logic doze_mode,
  input wire logic fault_done_pulse,
  // outputs
  input wire logic lcd_clk_tick,
  input wire logic pads_enable,
  input wire logic waveform_run,
  input wire logic regulator_run,
  input wire logic top_bias_rail_internal,
  input wire logic top_bias_rail_external,
  input wire logic irq
);
  logic [31:0] sh_ff;
  logic [2:0] pd_ff;
  wire take = hsel && htrans[1];
  // shadow of the control word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sh_ff <= 32'h0000_0000;
      pd_ff <= 3'h0;
    end else begin
      pd_ff <= {take && !hwrite && haddr == 32'h0000_0000,
                take && hwrite && haddr == 32'h0000_000C,
                take && hwrite && haddr == 32'h0000_0000};
      if (pd_ff[0]) sh_ff <= hwdata & seg_pkg::GCR_WMASK;
      if (pd_ff[1]) sh_ff[14] <= hwdata[0];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_dozed; (sh_ff[9] && sh_ff[7] && doze_mode) [*6]; endsequence
  sequence s_src;
    sh_ff[11] ? alt_src2_tick : alt_src1_tick;
  endsequence
  property p_rdback; pd_ff[2] |-> hrdata == sh_ff; endproperty
  property p_rail;
    $stable(sh_ff) |-> top_bias_rail_external == (sh_ff[17] && sh_ff[7])
      && top_bias_rail_internal == !(sh_ff[17] && sh_ff[7]);
  endproperty
  property p_safe; $stable(sh_ff) && sh_ff[15] |-> !pads_enable; endproperty
  property p_off;
    $stable(sh_ff) && !sh_ff[7] |->
      !pads_enable && !waveform_run && top_bias_rail_internal;
  endproperty
  property p_doze; s_dozed |-> !regulator_run && !waveform_run; endproperty
  property p_keep;
    (sh_ff[7] && !sh_ff[9]) [*3] |-> regulator_run && waveform_run;
  endproperty
  property p_irq; fault_done_pulse && sh_ff[14] |-> ##[1:3] irq; endproperty
  property p_div1;
    $stable(sh_ff) && sh_ff[13:12] == 2'h0 ##0 s_src |=> lcd_clk_tick;
  endproperty
  property p_cause;
    lcd_clk_tick |-> $past(alt_src1_tick) || $past(alt_src2_tick);
  endproperty
  a_rdback: assert property (p_rdback) else $error("bad readback");
  a_rail: assert property (p_rail) else $error("bad rail select");
  a_safe: assert property (p_safe) else $error("pads on in safe");
  a_off: assert property (p_off) else $error("driver off ignored");
  a_doze: assert property (p_doze) else $error("no doze stop");
  a_keep: assert property (p_keep) else $error("run lost");
  a_irq: assert property (p_irq) else $error("irq missing");
  a_div1: assert property (p_div1) else $error("tick missing");
  a_cause: assert property (p_cause) else $error("stray tick");
endmodule : seg_ctrl_sva

bind seg_global_ctrl seg_ctrl_sva seg_ctrl_sva_inst (.*);

// file: bench/seg_global_ctrl_tb.sv
// self-checking bench for the global control block
// drives the AHB-Lite port and event inputs directly
`timescale 1ns/1ps
module seg_global_ctrl_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = seg_pkg::HSIZE_WORD;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic alt_src1_tick = 1'b0;
  logic alt_src2_tick = 1'b0;
  logic doze_mode = 1'b0;
  logic fault_done_pulse = 1'b0;
  logic hready, hreadyout, hresp, lcd_clk_tick, frame_tick, pads_enable;
  logic waveform_run, charge_pump_run, bias_network_run, regulator_run;
  logic top_bias_rail_internal, top_bias_rail_external, irq;
  logic [31:0] hrdata, rd;
  int mismatches = 0;
  int compares = 0;
  int c, f;
  assign hready = hreadyout;
  always #25 hclk = ~hclk;
  seg_global_ctrl seg_global_ctrl_inst (.*);

  task automatic chk(input logic [31:0] g, e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [31:0] a, d);
    htrans <= seg_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= a;
    hsel <= 1'b1;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [31:0] a, d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [31:0] a, e);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, e);
    chk({30'h0, hreadyout, hresp}, 32'h2);
  endtask : rdc
  // pads, four runs, rails, irq
  task automatic outs(input logic [7:0] e, input logic [7:0] m = 8'hFF);
    repeat (6) @(posedge hclk);
    chk({24'h0, m & {pads_enable, waveform_run, charge_pump_run,
        bias_network_run, regulator_run, top_bias_rail_internal,
        top_bias_rail_external, irq}}, {24'h0, e});
  endtask : outs
  task automatic fpulse;
    fault_done_pulse <= 1'b1;
    @(posedge hclk);
    fault_done_pulse <= 1'b0;
  endtask : fpulse
  // selected source pulses every other cycle, other one stays high
  task automatic pul(input int n, input logic sel);
    c = 0;
    f = 0;
    for (int i = 0; i < 2 * n; i++) begin
      alt_src1_tick <= sel | !i[0];
      alt_src2_tick <= !sel | !i[0];
      @(posedge hclk);
      c += int'(lcd_clk_tick === 1'b1);
      f += int'(frame_tick === 1'b1);
    end
  endtask : pul
  task automatic sync(input logic sel, input logic fr);
    int k;
    k = 0;
    do begin
      pul(1, sel);
      k++;
    end while ((fr ? f : c) == 0 && k < 600);
    // no tick inside the limit counts as a failure
    if ((fr ? f : c) == 0) begin
      mismatches++;
      $display("ERROR t=%0t sync ticks got=%h exp=%h", $time, 0, 1);
    end
  endtask : sync
  task automatic wrap_up;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  initial begin
    #2_000_000;
    mismatches++;
    wrap_up();
  end

  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(32'h0, seg_pkg::GCR_RESET);
    outs(8'h04);
    wr(32'h0, 32'hFFFF_FFFF);
    rdc(32'h0, seg_pkg::GCR_WMASK);
    outs(8'h7A);
    wr(32'h0, 32'h0);
    outs(8'h04);
    wr(32'h0, 32'h0002_0000);
    wr(32'h0, 32'h0002_0080);
    outs(8'hFA);
    wr(32'h0, 32'h0002_0280);
    doze_mode <= 1'b1;
    outs(8'h02);
    wr(32'h0, 32'h0002_0080);
    outs(8'hFA);
    doze_mode <= 1'b0;
    wr(32'hC, 32'h0);
    fpulse();
    outs(8'hFA);
    rdc(32'h4, 32'h1);
    wr(32'hC, 32'h1);
    outs(8'hFB);
    fpulse();
    rdc(32'h0, 32'h0002_4080);
    wr(32'h8, 32'h1);
    outs(8'hFA);
    rdc(32'h4, 32'h0);
    wr(32'hC, 32'h0);
    wr(32'h10, 32'hFFFF_FFFF);
    rdc(32'h10, 32'h0);
    for (int s = 0; s < 2; s++) begin
      for (int k = 0; k < 4; k++) begin
        wr(32'h0, 32'h0002_0080 | (s << 11) | (k << 12));
        sync(s[0], 1'b0);
        pul(2 << (3 * k), s[0]);
        chk(c, 32'h2);
      end
    end
    for (int q = 0; q < 2; q++) begin
      wr(32'h0, 32'h0002_0080 | (q << 10));
      sync(1'b0, 1'b1);
      pul(int'(seg_pkg::FRAME_TICKS), 1'b0);
      chk(f, q + 1);
    end
    rdc(32'h4, 32'h2);
    wr(32'hC, 32'h2);
    outs(8'hFB);
    rdc(32'hC, 32'h2);
    wr(32'h8, 32'h2);
    outs(8'hFA);
    rdc(32'h4, 32'h0);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(32'h0, seg_pkg::GCR_RESET);
    outs(8'h04);
    wrap_up();
  end
endmodule : seg_global_ctrl_tb
